// *** rtc_pkg.sv ***
// Purpose: shared constants of the calendar clock block: register map, fields, reset values
// Assumes: 32-bit APB register words at byte offsets below
// Notes: all offsets are byte addresses
package rtc_pkg;
    // ====================
    // register offsets
    localparam logic [7:0] A_TIME = 8'h00;
    localparam logic [7:0] A_DATE = 8'h04;
    localparam logic [7:0] A_SUBS = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0C;
    localparam logic [7:0] A_PRESC = 8'h10;
    localparam logic [7:0] A_WUTR = 8'h14;
    localparam logic [7:0] A_ALRA = 8'h18;
    localparam logic [7:0] A_ALRB = 8'h1C;
    localparam logic [7:0] A_SHIFT = 8'h20;
    localparam logic [7:0] A_CALIB = 8'h24;
    localparam logic [7:0] A_TSTIME = 8'h28;
    localparam logic [7:0] A_TSDATE = 8'h2C;
    localparam logic [7:0] A_TSSUB = 8'h30;
    localparam logic [7:0] A_TAMP = 8'h34;
    localparam logic [7:0] A_STAT = 8'h38;
    localparam logic [7:0] A_MASK = 8'h3C;
    localparam logic [7:0] A_BKP0 = 8'h40;
    // ====================
    // reset values
    localparam logic [6:0] PRE_A_RST = 7'h7F;
    localparam logic [14:0] PRE_S_RST = 15'h00FF;
    localparam logic [15:0] WUT_RST = 16'hFFFF;
    localparam logic [5:0] DAY_RST = 6'h01;
    localparam logic [4:0] MON_RST = 5'h01;
    localparam logic [2:0] WDAY_RST = 3'h1;
    // ====================
    // field positions
    localparam int T_MIN = 8;
    localparam int T_HOUR = 16;
    localparam int T_PM = 22;
    localparam int D_MON = 8;
    localparam int D_WDAY = 13;
    localparam int D_YEAR = 16;
    localparam int AM_SEC = 7;
    localparam int AM_MIN = 15;
    localparam int AM_HOUR = 23;
    localparam int P_ASYNC = 16;
    localparam int SH_ADD1S = 31;
    localparam int CAL_P = 15;
    localparam int C_FMT12 = 0;
    localparam int C_CLKSEL = 1;
    localparam int C_REFEN = 3;
    localparam int C_REF60 = 4;
    localparam int C_WUTE = 5;
    localparam int C_ALRAE = 6;
    localparam int C_ALRBE = 7;
    localparam int C_TAMPE = 8;
    localparam int C_TSE = 10;
    localparam int C_TSTAMP = 11;
    localparam int C_WUCK = 12;
    localparam int CTRL_W = 14;
    localparam int S_ALRA = 0;
    localparam int S_ALRB = 1;
    localparam int S_WUT = 2;
    localparam int S_TAMP = 3;
    localparam int S_TS = 5;
    localparam int NFLAG = 6;
    // ====================
    // calibration window and reference clock counts
    localparam int CAL_WIN = 20;
    localparam int CAL_SLOT = 11;
    localparam logic [5:0] REF50_LAST = 6'h31;
    localparam logic [5:0] REF60_LAST = 6'h3B;
endpackage

// *** rtc_calendar_backup.sv ***
// Purpose: low-power BCD calendar clock with alarms, wakeup timer, tamper, timestamp, backup words
// Assumes: every clock source toggles far slower than MCLK; APB slave with no wait states
// Notes: BKP_RST clears the retained domain; SYS_RST clears only the bus side and synchronisers
//
// Contract
// - five 32-bit software backup words
// - backup words survive system reset, standby
// - clock and backup keep running every mode
// - BCD calendar fields, binary subsecond count
// - hours selectable 12 or 24 format
// - day rolls over at month length, leap
// - two alarms that can wake chip
// - periodic wakeup timer, programmable resolution, period
// - on-the-fly shift of 1 to 32767 subsecond counts
// - optional 50/60 Hz reference second source
// - digital calibration at about 1 ppm
// - two filtered tamper pins raise wake events
// - timestamp captures calendar on pin or tamper
// - timestamp event can wake the chip
// - clock chosen from four sources
//
// Implementation choices: the placing of the registers and register access over APB.
module rtc_calendar_backup #(
    parameter int BKP_NUM = 5
) (
    // clock and resets
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic BKP_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // calendar clock sources and reference
    input wire logic CLK_XTAL,
    input wire logic CLK_OSC,
    input wire logic CLK_LSI,
    input wire logic CLK_HSE,
    input wire logic REF_IN,
    // event pins
    input wire logic [1:0] TAMPER_IN,
    input wire logic TSTAMP_IN,
    // interrupt and wake request
    output logic IRQ
);
    // ====================
    // elaboration check
    if (BKP_NUM < 1 || BKP_NUM > 48)
    begin : g_chk
        $error("BKP_NUM must lie in 1..48");
    end

    // ====================
    // functions
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [5:0] month_last(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            5'h02: month_last = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = 6'h30;
            default: month_last = 6'h31;
        endcase
    endfunction

    function automatic logic alarm_hit(input logic [23:0] cfg, input logic [31:0] t);
        alarm_hit = (cfg[rtc_pkg::AM_SEC] || cfg[6:0] == t[6:0])
                 && (cfg[rtc_pkg::AM_MIN] || cfg[14:8] == t[14:8])
                 && (cfg[rtc_pkg::AM_HOUR] || cfg[22:16] == t[22:16]);
    endfunction

    function automatic logic [7:0] bkp_addr(input int i);
        bkp_addr = 8'(int'(rtc_pkg::A_BKP0) + 4 * i);
    endfunction

    // ====================
    // declarations
    logic [7:0] s1_q, s2_q;
    logic src_q, ref_q, ts_q, extra_q, tick_dly_q;
    logic [rtc_pkg::CAL_WIN-1:0] cal_win_q;
    logic [6:0] pre_a_q, cnt_a_q;
    logic [14:0] pre_s_q, cnt_s_q;
    logic [5:0] ref_cnt_q;
    logic [6:0] sec_q, min_q;
    logic [5:0] hour_q, day_q;
    logic pm_q;
    logic [4:0] mon_q;
    logic [2:0] wday_q;
    logic [7:0] year_q;
    logic [rtc_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0] wutr_q, wut_cnt_q;
    logic [2:0] wdiv_q;
    logic [23:0] alra_q, alrb_q;
    logic [8:0] calm_q;
    logic calp_q;
    logic [3:0] tfilt_q;
    logic [3:0] tcnt_q [2];
    logic [1:0] tdone_q;
    logic [31:0] ts_time_q, ts_date_q;
    logic [14:0] ts_sub_q;
    logic [rtc_pkg::NFLAG-1:0] flag_q, mask_q, ev;
    logic [31:0] bkp_q [BKP_NUM];
    logic [31:0] prdata_q, rd_val;
    logic err_q, rd_hit;
    logic wr, src_sel, raw, drop, step, ptick, ref_sec, shift_wr, sec_tick;
    logic [5:0] ref_last;
    logic wrap_s, wrap_m, wrap_h, wrap_d;
    logic [7:0] sec_i, min_i, hour_i, day_i, mon_i, year_i;
    logic [31:0] time_w, date_w;
    logic wut_clk, wut_ev, ts_ev;
    logic [2:0] wmask;
    logic [1:0] tfire;

    // ====================
    // pin synchronisers
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end
        else
        begin
            s1_q <= {TSTAMP_IN, TAMPER_IN, REF_IN, CLK_HSE, CLK_LSI, CLK_OSC, CLK_XTAL};
            s2_q <= s1_q;
        end
    end

    // a source switch may give one spurious pulse
    assign src_sel = s2_q[ctrl_q[rtc_pkg::C_CLKSEL +: 2]];

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            src_q <= 1'b0;
            ref_q <= 1'b0;
            ts_q <= 1'b0;
        end
        else
        begin
            src_q <= src_sel;
            ref_q <= s2_q[4];
            ts_q <= s2_q[7];
        end
    end

    assign raw = src_sel & ~src_q;

    // ====================
    // calibration: drop calm_q or add 512 pulses per 2^20
    assign drop = raw && cal_win_q[rtc_pkg::CAL_SLOT-1:0] == '0
               && cal_win_q[rtc_pkg::CAL_WIN-1:rtc_pkg::CAL_SLOT] < calm_q;
    assign step = (raw & ~drop) | extra_q;

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            cal_win_q <= '0;
            extra_q <= 1'b0;
        end
        else
        begin
            if (raw)
                cal_win_q <= cal_win_q + 1'b1;
            extra_q <= raw & calp_q & (cal_win_q[rtc_pkg::CAL_SLOT-1:0] == '0);
        end
    end

    // ====================
    // prescalers, shift and reference second
    assign wr = PSEL & PENABLE & PWRITE;
    assign shift_wr = wr && PADDR == rtc_pkg::A_SHIFT;
    assign ptick = step && cnt_a_q == 7'h00 && cnt_s_q == 15'h0000;
    assign ref_last = ctrl_q[rtc_pkg::C_REF60] ? rtc_pkg::REF60_LAST : rtc_pkg::REF50_LAST;
    assign ref_sec = s2_q[4] && !ref_q && ref_cnt_q == ref_last;
    // the reference input replaces the prescaler second when enabled
    assign sec_tick = (ctrl_q[rtc_pkg::C_REFEN] ? ref_sec : ptick)
                    | (shift_wr & PWDATA[rtc_pkg::SH_ADD1S]);

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            cnt_a_q <= rtc_pkg::PRE_A_RST;
            cnt_s_q <= rtc_pkg::PRE_S_RST;
        end
        else if (shift_wr)
            cnt_s_q <= cnt_s_q + PWDATA[14:0];
        else if (step)
        begin
            if (cnt_a_q != 7'h00)
                cnt_a_q <= cnt_a_q - 7'h01;
            else
            begin
                cnt_a_q <= pre_a_q;
                cnt_s_q <= (cnt_s_q == 15'h0000) ? pre_s_q : cnt_s_q - 15'h0001;
            end
        end
    end

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
            ref_cnt_q <= 6'h00;
        else if (!ctrl_q[rtc_pkg::C_REFEN])
            ref_cnt_q <= 6'h00;
        else if (s2_q[4] && !ref_q)
            ref_cnt_q <= (ref_cnt_q == ref_last) ? 6'h00 : ref_cnt_q + 6'h01;
    end

    // ====================
    // calendar
    assign sec_i = bcd_inc({1'b0, sec_q});
    assign min_i = bcd_inc({1'b0, min_q});
    assign hour_i = bcd_inc({2'b00, hour_q});
    assign day_i = bcd_inc({2'b00, day_q});
    assign mon_i = bcd_inc({3'b000, mon_q});
    assign year_i = bcd_inc(year_q);
    assign wrap_s = sec_q == 7'h59;
    assign wrap_m = min_q == 7'h59;
    assign wrap_h = ctrl_q[rtc_pkg::C_FMT12] ? (hour_q == 6'h11 && pm_q) : (hour_q == 6'h23);
    assign wrap_d = day_q == month_last(mon_q, year_q);
    assign time_w = {9'h000, pm_q, hour_q, 1'b0, min_q, 1'b0, sec_q};
    assign date_w = {8'h00, year_q, wday_q, mon_q, 2'b00, day_q};

    // retained: keeps its time through system reset, though the synchronisers pass no pulses while SYS_RST is high
    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            sec_q <= 7'h00;
            min_q <= 7'h00;
            hour_q <= 6'h00;
            pm_q <= 1'b0;
        end
        else if (wr && PADDR == rtc_pkg::A_TIME)
        begin
            sec_q <= PWDATA[6:0];
            min_q <= PWDATA[rtc_pkg::T_MIN +: 7];
            hour_q <= PWDATA[rtc_pkg::T_HOUR +: 6];
            pm_q <= PWDATA[rtc_pkg::T_PM];
        end
        else if (sec_tick)
        begin
            sec_q <= wrap_s ? 7'h00 : sec_i[6:0];
            if (wrap_s)
                min_q <= wrap_m ? 7'h00 : min_i[6:0];
            if (wrap_s && wrap_m)
            begin
                if (ctrl_q[rtc_pkg::C_FMT12])
                begin
                    hour_q <= (hour_q == 6'h12) ? 6'h01 : hour_i[5:0];
                    if (hour_q == 6'h11)
                        pm_q <= ~pm_q;
                end
                else
                    hour_q <= wrap_h ? 6'h00 : hour_i[5:0];
            end
        end
    end

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            day_q <= rtc_pkg::DAY_RST;
            mon_q <= rtc_pkg::MON_RST;
            wday_q <= rtc_pkg::WDAY_RST;
            year_q <= 8'h00;
        end
        else if (wr && PADDR == rtc_pkg::A_DATE)
        begin
            day_q <= PWDATA[5:0];
            mon_q <= PWDATA[rtc_pkg::D_MON +: 5];
            wday_q <= PWDATA[rtc_pkg::D_WDAY +: 3];
            year_q <= PWDATA[rtc_pkg::D_YEAR +: 8];
        end
        else if (sec_tick && wrap_s && wrap_m && wrap_h)
        begin
            wday_q <= (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
            day_q <= wrap_d ? 6'h01 : day_i[5:0];
            if (wrap_d)
                mon_q <= (mon_q == 5'h12) ? 5'h01 : mon_i[4:0];
            if (wrap_d && mon_q == 5'h12)
                year_q <= (year_q == 8'h99) ? 8'h00 : year_i;
        end
    end

    // ====================
    // configuration registers
    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            ctrl_q <= '0;
            pre_a_q <= rtc_pkg::PRE_A_RST;
            pre_s_q <= rtc_pkg::PRE_S_RST;
            wutr_q <= rtc_pkg::WUT_RST;
            alra_q <= 24'h000000;
            alrb_q <= 24'h000000;
            calm_q <= 9'h000;
            calp_q <= 1'b0;
            tfilt_q <= 4'h0;
            mask_q <= '0;
        end
        else if (wr)
        begin
            case (PADDR)
                rtc_pkg::A_CTRL: ctrl_q <= PWDATA[rtc_pkg::CTRL_W-1:0];
                rtc_pkg::A_PRESC:
                begin
                    pre_s_q <= PWDATA[14:0];
                    pre_a_q <= PWDATA[rtc_pkg::P_ASYNC +: 7];
                end
                rtc_pkg::A_WUTR: wutr_q <= PWDATA[15:0];
                rtc_pkg::A_ALRA: alra_q <= PWDATA[23:0];
                rtc_pkg::A_ALRB: alrb_q <= PWDATA[23:0];
                rtc_pkg::A_CALIB:
                begin
                    calm_q <= PWDATA[8:0];
                    calp_q <= PWDATA[rtc_pkg::CAL_P];
                end
                rtc_pkg::A_TAMP: tfilt_q <= PWDATA[3:0];
                rtc_pkg::A_MASK: mask_q <= PWDATA[rtc_pkg::NFLAG-1:0];
                default: ;
            endcase
        end
    end

    // ====================
    // alarms: compared a cycle after the tick, on the new time
    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
            tick_dly_q <= 1'b0;
        else
            tick_dly_q <= sec_tick;
    end

    assign ev[rtc_pkg::S_ALRA] = tick_dly_q & ctrl_q[rtc_pkg::C_ALRAE] & alarm_hit(alra_q, time_w);
    assign ev[rtc_pkg::S_ALRB] = tick_dly_q & ctrl_q[rtc_pkg::C_ALRBE] & alarm_hit(alrb_q, time_w);

    // ====================
    // wakeup timer: clock is pulses/2, /4, /8 or the second tick
    always_comb
    begin
        case (ctrl_q[rtc_pkg::C_WUCK +: 2])
            2'h0: wmask = 3'h1;
            2'h1: wmask = 3'h3;
            default: wmask = 3'h7;
        endcase
    end

    assign wut_clk = (ctrl_q[rtc_pkg::C_WUCK +: 2] == 2'h3) ? sec_tick
                   : (step && (wdiv_q & wmask) == wmask);
    assign wut_ev = ctrl_q[rtc_pkg::C_WUTE] && wut_clk && wut_cnt_q == 16'h0000;
    assign ev[rtc_pkg::S_WUT] = wut_ev;

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            wdiv_q <= 3'h0;
            wut_cnt_q <= rtc_pkg::WUT_RST;
        end
        else
        begin
            if (step)
                wdiv_q <= wdiv_q + 3'h1;
            if (!ctrl_q[rtc_pkg::C_WUTE])
                wut_cnt_q <= wutr_q;
            else if (wut_clk)
                wut_cnt_q <= wut_ev ? wutr_q : wut_cnt_q - 16'h0001;
        end
    end

    // ====================
    // tamper: high for tfilt_q pulses; zero fires at once
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            tfire[i] = s2_q[5 + i] && !tdone_q[i]
                    && (tfilt_q == 4'h0 || (step && tcnt_q[i] == tfilt_q - 4'h1));
    end

    assign ev[rtc_pkg::S_TAMP +: 2] = tfire & ctrl_q[rtc_pkg::C_TAMPE +: 2];

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            tcnt_q[0] <= 4'h0;
            tcnt_q[1] <= 4'h0;
            tdone_q <= 2'b00;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!s2_q[5 + i])
                begin
                    tcnt_q[i] <= 4'h0;
                    tdone_q[i] <= 1'b0;
                end
                else if (tfire[i])
                    tdone_q[i] <= 1'b1;
                else if (step && !tdone_q[i])
                    tcnt_q[i] <= tcnt_q[i] + 4'h1;
            end
        end
    end

    // ====================
    // timestamp
    assign ts_ev = ctrl_q[rtc_pkg::C_TSE]
                && ((s2_q[7] && !ts_q) || (ctrl_q[rtc_pkg::C_TSTAMP] && |ev[rtc_pkg::S_TAMP +: 2]));
    assign ev[rtc_pkg::S_TS] = ts_ev;

    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            ts_time_q <= 32'h00000000;
            ts_date_q <= 32'h00000000;
            ts_sub_q <= 15'h0000;
        end
        else if (ts_ev)
        begin
            ts_time_q <= time_w;
            ts_date_q <= date_w;
            ts_sub_q <= cnt_s_q;
        end
    end

    // ====================
    // sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
            flag_q <= '0;
        else if (wr && PADDR == rtc_pkg::A_STAT)
            flag_q <= (flag_q & ~PWDATA[rtc_pkg::NFLAG-1:0]) | ev;
        else
            flag_q <= flag_q | ev;
    end

    // also the wake request in stop and standby
    assign IRQ = |(flag_q & mask_q);

    // ====================
    // backup words: only BKP_RST clears them
    always_ff @(posedge MCLK or posedge BKP_RST)
    begin
        if (BKP_RST)
        begin
            for (int i = 0; i < BKP_NUM; i++)
                bkp_q[i] <= 32'h00000000;
        end
        else
        begin
            for (int i = 0; i < BKP_NUM; i++)
                if (wr && PADDR == bkp_addr(i))
                    bkp_q[i] <= PWDATA;
        end
    end

    // ====================
    // apb read side: data latched in the setup cycle, zero wait states
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        case (PADDR)
            rtc_pkg::A_TIME: rd_val = time_w;
            rtc_pkg::A_DATE: rd_val = date_w;
            rtc_pkg::A_SUBS: rd_val = {17'h00000, cnt_s_q};
            rtc_pkg::A_CTRL: rd_val = {18'h00000, ctrl_q};
            rtc_pkg::A_PRESC: rd_val = {9'h000, pre_a_q, 1'b0, pre_s_q};
            rtc_pkg::A_WUTR: rd_val = {16'h0000, wutr_q};
            rtc_pkg::A_ALRA: rd_val = {8'h00, alra_q};
            rtc_pkg::A_ALRB: rd_val = {8'h00, alrb_q};
            rtc_pkg::A_SHIFT: rd_val = 32'h00000000;
            rtc_pkg::A_CALIB: rd_val = {16'h0000, calp_q, 6'h00, calm_q};
            rtc_pkg::A_TSTIME: rd_val = ts_time_q;
            rtc_pkg::A_TSDATE: rd_val = ts_date_q;
            rtc_pkg::A_TSSUB: rd_val = {17'h00000, ts_sub_q};
            rtc_pkg::A_TAMP: rd_val = {28'h0000000, tfilt_q};
            rtc_pkg::A_STAT: rd_val = {26'h0000000, flag_q};
            rtc_pkg::A_MASK: rd_val = {26'h0000000, mask_q};
            default: rd_hit = 1'b0;
        endcase
        for (int i = 0; i < BKP_NUM; i++)
        begin
            if (PADDR == bkp_addr(i))
            begin
                rd_hit = 1'b1;
                rd_val = bkp_q[i];
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            prdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end
        else if (PSEL && !PENABLE)
        begin
            prdata_q <= PWRITE ? 32'h00000000 : rd_val;
            err_q <= ~rd_hit;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & err_q;

endmodule // rtc_calendar_backup

// *** rtc_calendar_backup_props.sv ***
// Purpose: port checker of the calendar clock block
// Assumes: apb slave with no wait states
// Notes: sees only bus, resets and irq
module rtc_calendar_backup_props #(
    parameter int BKP_NUM = 5
) (
    // clock and resets
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic BKP_RST,
    // apb and irq
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    // ====================
    // bus checks
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic acc;
    logic setup;
    logic bad;
    assign acc = PSEL && PENABLE;
    assign setup = PSEL && !PENABLE;
    // backup words end the map, so anything past the last one errors
    assign bad = PADDR[1:0] != 2'h0 || int'(PADDR) >= 64 + 4 * BKP_NUM;
    a_ready_high: assert property (PREADY) else $error("pready low");
    a_err_in_access: assert property (PSLVERR |-> acc) else $error("pslverr outside access");
    a_unmapped_err: assert property (acc && bad |-> PSLVERR && PRDATA == 32'h0) else $error("no error");
    a_mapped_ok: assert property (acc && !bad |-> !PSLVERR) else $error("error on mapped");
    a_write_rdata: assert property (acc && PWRITE |-> PRDATA == 32'h0) else $error("rdata on write");
    a_rdata_hold: assert property (!$past(setup) |-> $stable(PRDATA)) else $error("rdata moved");
    a_mask_irq: assert property (acc && PWRITE && PADDR == rtc_pkg::A_MASK && PWDATA[5:0] == 6'h00
        |=> !IRQ) else $error("irq with mask clear");
    a_bkp_irq: assert property (BKP_RST |-> !IRQ) else $error("irq in reset");
    c_err: cover property (acc && PSLVERR);
    c_irq: cover property ($rose(IRQ));
    c_clear: cover property (acc && PWRITE && PADDR == rtc_pkg::A_STAT);
endmodule // rtc_calendar_backup_props

bind rtc_calendar_backup rtc_calendar_backup_props #(.BKP_NUM(BKP_NUM)) u_props (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .BKP_RST(BKP_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

// *** rtc_src_model.sv ***
// Purpose: far side: four calendar clocks, reference, event pins
// Assumes: sources run free, unrelated to the system clock
// Notes: event pins follow the bench's requests
module rtc_src_model (
    // bench requests
    input wire logic [1:0] tamp_req,
    input wire logic ts_req,
    // pins toward the block
    output logic [3:0] src_clk,
    output logic ref_clk,
    output logic [1:0] tamper_pin,
    output logic ts_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // sources, halves at least four system periods
    initial
    begin
        src_clk = 4'h0;
        ref_clk = 1'b0;
    end
    always #40 src_clk[0] = ~src_clk[0];
    always #44 src_clk[1] = ~src_clk[1];
    always #48 src_clk[2] = ~src_clk[2];
    always #52 src_clk[3] = ~src_clk[3];
    always #200 ref_clk = ~ref_clk;
    assign tamper_pin = tamp_req;
    assign ts_pin = ts_req;
endmodule // rtc_src_model

// *** rtc_calendar_backup_bench.sv ***
// Purpose: self-checking bench of the calendar clock block
// Assumes: one second is two source pulses
// Notes: polls stand in for fixed waits
module rtc_calendar_backup_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] c, d, t, et, ed;} row_t;
    logic mclk, sys_rst, bkp_rst, psel, penable, pwrite, pready, pslverr, irq, ts_req, ref_clk, ts_pin, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] tamp_req, tamp_pin;
    logic [3:0] src;
    int failures, checked;
    logic [7:0] ra[5] = '{rtc_pkg::A_TIME, rtc_pkg::A_DATE, rtc_pkg::A_PRESC, rtc_pkg::A_WUTR, rtc_pkg::A_STAT};
    logic [31:0] rv[5] = '{32'h0, 32'h00002101, 32'h007F00FF, 32'h0000FFFF, 32'h0};
    row_t rows[4] = '{'{32'h0, 32'h00242228, 32'h00235959, 32'h0, 32'h00240229},
        '{32'h2, 32'h00242229, 32'h00235959, 32'h0, 32'h00240301},
        '{32'h4, 32'h00232228, 32'h00235959, 32'h0, 32'h00230301},
        '{32'h7, 32'h00231231, 32'h00515959, 32'h00120000, 32'h00240101}};
    rtc_calendar_backup u_dut (.MCLK(mclk), .SYS_RST(sys_rst), .BKP_RST(bkp_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CLK_XTAL(src[0]), .CLK_OSC(src[1]), .CLK_LSI(src[2]), .CLK_HSE(src[3]), .REF_IN(ref_clk),
        .TAMPER_IN(tamp_pin), .TSTAMP_IN(ts_pin), .IRQ(irq));
    rtc_src_model u_src (.tamp_req(tamp_req), .ts_req(ts_req), .src_clk(src), .ref_clk(ref_clk),
        .tamper_pin(tamp_pin), .ts_pin(ts_pin));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ====================
    // tasks
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // idle edge at the end keeps psel from being driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
        begin
            failures++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        while ((rd & m) !== exp && n < 3000);
        check(nm, rd & m, exp);
    endtask
    // ====================
    // sequence
    initial
    begin
        {psel, penable, pwrite, ts_req, sys_rst, bkp_rst} = 6'h03;
        {paddr, pwdata, tamp_req, failures, checked} = '0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        bkp_rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 5; i++) poll("reset value", ra[i], 32'hFFFFFFFF, rv[i]);
        for (int i = 0; i < 5; i++) apb(1'b1, rtc_pkg::A_BKP0 + 8'(4 * i), 32'hA5A50000 | 32'(i));
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 5; i++) poll("backup", rtc_pkg::A_BKP0 + 8'(4 * i), '1, 32'hA5A50000 | 32'(i));
        apb(1'b0, 8'h54, 32'h0);
        check("unmapped", {31'h0, er}, 32'h1);
        apb(1'b1, rtc_pkg::A_PRESC, 32'h1);
        foreach (rows[i])
        begin
            apb(1'b1, rtc_pkg::A_CTRL, rows[i].c);
            apb(1'b1, rtc_pkg::A_DATE, rows[i].d);
            apb(1'b1, rtc_pkg::A_TIME, rows[i].t);
            poll("time", rtc_pkg::A_TIME, 32'h007F7F7F, rows[i].et);
            poll("date", rtc_pkg::A_DATE, 32'h00FF1FFF, rows[i].ed);
        end
        apb(1'b1, rtc_pkg::A_MASK, 32'h3F);
        apb(1'b1, rtc_pkg::A_ALRA, 32'h00808002);
        apb(1'b1, rtc_pkg::A_CTRL, 32'h40);
        poll("alarm", rtc_pkg::A_STAT, 32'h3F, 32'h01);
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, rtc_pkg::A_STAT, 32'h3F);
        poll("cleared", rtc_pkg::A_STAT, 32'h3F, 32'h0);
        apb(1'b1, rtc_pkg::A_WUTR, 32'h3);
        apb(1'b1, rtc_pkg::A_CTRL, 32'h20);
        poll("wakeup", rtc_pkg::A_STAT, 32'h3F, 32'h04);
        apb(1'b1, rtc_pkg::A_CTRL, 32'hD00);
        apb(1'b1, rtc_pkg::A_STAT, 32'h3F);
        tamp_req <= 2'h1;
        poll("tamper", rtc_pkg::A_STAT, 32'h3F, 32'h28);
        apb(1'b1, rtc_pkg::A_MASK, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, rtc_pkg::A_STAT, 32'h3F);
        tamp_req <= 2'h0;
        ts_req <= 1'b1;
        poll("stamp", rtc_pkg::A_STAT, 32'h3F, 32'h20);
        poll("stamp date", rtc_pkg::A_TSDATE, 32'h00FF1FFF, 32'h00240101);
        print_verdict();
    end
endmodule // rtc_calendar_backup_bench
